// ### core/rsc_pkg.sv
// Purpose: shared constants and carrier types for the regulator and external enable slot block
// Assumes: 32-bit classic Wishbone, word index = byte address / 4
// Notes:   register data is 16 bits wide in the low half of the bus word; status also carries millivolts in bits 26:16
package rsc_pkg;

	// word indexes of the registers (byte address is four times the index)
	localparam logic [15:0] IDX_REG_ON    = 16'h4087;
	localparam logic [15:0] IDX_REG_SLEEP = 16'h4088;
	localparam logic [15:0] IDX_EXT_CTRL  = 16'h4089;
	localparam logic [15:0] IDX_ENABLES   = 16'h40F0;
	localparam logic [15:0] IDX_STATUS    = 16'h40F1;

	// field positions
	localparam int SLOT_LSB   = 13;
	localparam int VSEL_LSB   = 0;
	localparam int SRC_LSB    = 11;
	localparam int HWCENA_BIT = 8;
	localparam int XSLP_LSB   = 5;
	localparam int EXT_SW_BIT = 0;
	localparam int REG_SW_BIT = 1;
	localparam int MV_LSB     = 16;

	// reset values
	localparam logic [2:0] SLOT_RST = 3'h0;
	localparam logic [3:0] VSEL_RST = 4'h0;
	localparam logic [1:0] SRC_RST  = 2'h0;

	// slot codes
	localparam logic [2:0] SLOT_NONE = 3'h0;
	localparam logic [2:0] SLOT_FIRST = 3'h1;
	localparam logic [2:0] SLOT_LAST = 3'h5;
	localparam logic [2:0] SLOT_HWEN1 = 3'h6;
	localparam logic [2:0] SLOT_HWEN2 = 3'h7;

	// sleep voltage scale in millivolts
	localparam logic [10:0] VMIN_MV  = 11'h320;
	localparam logic [10:0] VSTEP_MV = 11'h032;

	// hardware control source codes
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_ONE  = 2'h1;
	localparam logic [1:0] SRC_TWO  = 2'h2;

	// whole state of the block
	typedef struct packed {
		logic [2:0]  reg_on_slot;
		logic [3:0]  reg_on_vsel;
		logic [2:0]  reg_slp_slot;
		logic [3:0]  reg_slp_vsel;
		logic [2:0]  ext_on_slot;
		logic [1:0]  ext_src;
		logic        ext_hwcena;
		logic [2:0]  ext_slp_slot;
		logic        ext_sw;
		logic        reg_sw;
		logic        reg_sleep;
		logic        reg_en;
		logic [3:0]  reg_vsel;
		logic        ext_en;
		logic        ack;
		logic [31:0] dat;
	} rsc_state_t;

	// sequencer event carrier
	typedef struct packed {
		logic       stb;
		logic       sleep;
		logic [2:0] slot;
	} rsc_seq_t;

endpackage : rsc_pkg

// ### core/rsc_sync.sv
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
module rsc_sync #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_r;

	// two flops, first feeds only the second
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= '0;
			dout   <= '0;
		end
		else
		begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule : rsc_sync

// ### core/rsc_slot_ctrl.sv
// Purpose: slot assignments for one regulator and one external enable output
// Assumes: sequencer strobes come from logic on REF_CLK; pins are asynchronous
// Notes:   registers on classic Wishbone, one cycle wait then ack
// Functional notes
// - sleep codes 000, 110, 111 move regulator to sleep in slot 5, 3, 1
// - sleep codes 001 to 101 disable regulator in slots 5 down to 1
// - with hardware enable assigned, codes 001 to 101 enter sleep instead of disabling
// - sleep voltage code gives 0.80V plus 50mV per step up to 1.55V
// - external on-slot 110, 111 hand the output to hardware enable 1, 2
// - control source 00 none, 01 input 1, 10 input 2, 11 either
// - control enable 0: output follows only the software enable bit
// - control enable 1: active selected control input forces the output low
// - external sleep codes 001 to 101 de-assert in slots 5 down to 1; others nothing
// - regulator on-slot: 000 never, 001 to 101 slots 1 to 5, 110/111 hardware enable
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module rsc_slot_ctrl
	import rsc_pkg::*;
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        ARST_N,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [17:0] WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// sequencer timeslot engine
	input  wire logic        SEQ_SLOT_STB,
	input  wire logic        SEQ_SLEEP,
	input  wire logic [2:0]  SEQ_SLOT,
	// hardware enable and control pins
	input  wire logic [1:0]  HWEN_PIN,
	input  wire logic [1:0]  HW_CTRL_PIN,
	// regulator and external enable
	output logic             REG_EN,
	output logic             REG_SLEEP,
	output logic      [3:0]  REG_VSEL,
	output logic             EXT_EN
);

	rsc_state_t s_r;
	rsc_state_t s_nxt;
	rsc_seq_t   seq;
	logic [3:0] pins_s;
	logic [1:0] hwen_s;
	logic [1:0] hw_ctrl_s;
	logic       wr_go;
	logic       wrote_r;

	// true when a startup slot code fires in this slot
	function automatic logic on_hit(input logic [2:0] code, input logic [2:0] slot);
		return (code >= SLOT_FIRST) && (code <= SLOT_LAST) && (code == slot);
	endfunction : on_hit

	// sleep slot number for a regulator sleep code
	function automatic logic [2:0] slp_slot(input logic [2:0] code);
		logic [2:0] r;
		r = 3'h0;
		case (code)
			3'h0, 3'h1: r = 3'h5;
			3'h2:       r = 3'h4;
			3'h3, 3'h6: r = 3'h3;
			3'h4:       r = 3'h2;
			default:    r = 3'h1;
		endcase
		return r;
	endfunction : slp_slot

	// codes that mean disable in a slot
	function automatic logic is_dis(input logic [2:0] code);
		return (code >= SLOT_FIRST) && (code <= SLOT_LAST);
	endfunction : is_dis

	// hardware enable level picked by an on-slot code
	function automatic logic hw_sel(input logic [2:0] code, input logic [1:0] hw);
		return (code == SLOT_HWEN1) ? hw[0] : hw[1];
	endfunction : hw_sel

	// byte-lane merge of the 16-bit register image
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = d[7:0];
		if (sel[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : merge

	// millivolt value of a voltage code
	function automatic logic [10:0] to_mv(input logic [3:0] code);
		return VMIN_MV + 11'(code) * VSTEP_MV;
	endfunction : to_mv

	// pin levels pass two flops
	rsc_sync #(.W(4)) u_sync (
		.clk    (REF_CLK),
		.arst_n (ARST_N),
		.din    ({HW_CTRL_PIN, HWEN_PIN}),
		.dout   (pins_s)
	);

	assign hwen_s    = pins_s[1:0];
	assign hw_ctrl_s = pins_s[3:2];
	assign seq       = '{stb: SEQ_SLOT_STB, sleep: SEQ_SLEEP, slot: SEQ_SLOT};
	assign wr_go     = WB_CYC_I && WB_STB_I && WB_WE_I && s_r.ack;

	// next state: bus, sequencer events, outputs
	always_comb
	begin
		logic [15:0] img;
		logic        hw_ctrl_act;
		logic        ext_base;
		img         = 16'h0000;
		hw_ctrl_act = 1'b0;
		ext_base    = 1'b0;
		s_nxt       = s_r;
		// ack one cycle after request, dropped after one cycle
		s_nxt.ack = WB_CYC_I && WB_STB_I && !s_r.ack;
		s_nxt.dat = 32'h0000_0000;
		if (s_nxt.ack)
		begin
			case (WB_ADR_I[17:2])
				IDX_REG_ON:    s_nxt.dat[15:0] = {s_r.reg_on_slot, 9'h000, s_r.reg_on_vsel};
				IDX_REG_SLEEP: s_nxt.dat[15:0] = {s_r.reg_slp_slot, 9'h000, s_r.reg_slp_vsel};
				IDX_EXT_CTRL:  s_nxt.dat[15:0] = {s_r.ext_on_slot, s_r.ext_src, 2'h0,
					s_r.ext_hwcena, s_r.ext_slp_slot, 5'h00};
				IDX_ENABLES:   s_nxt.dat[1:0] = {s_r.reg_sw, s_r.ext_sw};
				IDX_STATUS:    s_nxt.dat = {5'h00, to_mv(s_r.reg_vsel), 9'h000, pins_s,
					s_r.ext_en, s_r.reg_sleep, s_r.reg_en};
				default:       s_nxt.dat = 32'h0000_0000;
			endcase
		end
		// writes land on the edge after the one that shows ack
		if (wr_go)
		begin
			case (WB_ADR_I[17:2])
				IDX_REG_ON:
				begin
					img = merge({s_r.reg_on_slot, 9'h000, s_r.reg_on_vsel}, WB_DAT_I, WB_SEL_I);
					s_nxt.reg_on_slot = img[SLOT_LSB+:3];
					s_nxt.reg_on_vsel = img[VSEL_LSB+:4];
				end
				IDX_REG_SLEEP:
				begin
					img = merge({s_r.reg_slp_slot, 9'h000, s_r.reg_slp_vsel}, WB_DAT_I, WB_SEL_I);
					s_nxt.reg_slp_slot = img[SLOT_LSB+:3];
					s_nxt.reg_slp_vsel = img[VSEL_LSB+:4];
				end
				IDX_EXT_CTRL:
				begin
					img = merge({s_r.ext_on_slot, s_r.ext_src, 2'h0, s_r.ext_hwcena,
						s_r.ext_slp_slot, 5'h00}, WB_DAT_I, WB_SEL_I);
					s_nxt.ext_on_slot  = img[SLOT_LSB+:3];
					s_nxt.ext_src      = img[SRC_LSB+:2];
					s_nxt.ext_hwcena   = img[HWCENA_BIT];
					s_nxt.ext_slp_slot = img[XSLP_LSB+:3];
				end
				IDX_ENABLES:
				begin
					if (WB_SEL_I[0])
					begin
						s_nxt.ext_sw = WB_DAT_I[EXT_SW_BIT];
						s_nxt.reg_sw = WB_DAT_I[REG_SW_BIT];
					end
				end
				default: s_nxt.reg_sw = s_nxt.reg_sw;
			endcase
		end
		// sequencer events come after software so they win
		if (seq.stb && !seq.sleep)
		begin
			if (on_hit(s_r.reg_on_slot, seq.slot))
			begin
				s_nxt.reg_sw    = 1'b1;
				s_nxt.reg_sleep = 1'b0;
			end
			if (on_hit(s_r.ext_on_slot, seq.slot))
				s_nxt.ext_sw = 1'b1;
		end
		if (seq.stb && seq.sleep)
		begin
			if (slp_slot(s_r.reg_slp_slot) == seq.slot)
			begin
				if (is_dis(s_r.reg_slp_slot) && (s_r.reg_on_slot < SLOT_HWEN1))
					s_nxt.reg_sw = 1'b0;
				else
					s_nxt.reg_sleep = 1'b1;
			end
			if (is_dis(s_r.ext_slp_slot) && slp_slot(s_r.ext_slp_slot) == seq.slot)
				s_nxt.ext_sw = 1'b0;
		end
		// regulator enable source, hardware pin or enable bit
		if (s_nxt.reg_on_slot >= SLOT_HWEN1)
			s_nxt.reg_en = hw_sel(s_nxt.reg_on_slot, hwen_s);
		else
			s_nxt.reg_en = s_nxt.reg_sw;
		s_nxt.reg_vsel = s_nxt.reg_sleep ? s_nxt.reg_slp_vsel : s_nxt.reg_on_vsel;
		// hardware control source select
		case (s_nxt.ext_src)
			SRC_NONE: hw_ctrl_act = 1'b0;
			SRC_ONE:  hw_ctrl_act = hw_ctrl_s[0];
			SRC_TWO:  hw_ctrl_act = hw_ctrl_s[1];
			default:  hw_ctrl_act = hw_ctrl_s[0] || hw_ctrl_s[1];
		endcase
		if (s_nxt.ext_on_slot >= SLOT_HWEN1)
			ext_base = hw_sel(s_nxt.ext_on_slot, hwen_s);
		else
			ext_base = s_nxt.ext_sw;
		if (s_nxt.ext_hwcena)
			s_nxt.ext_en = ext_base && !hw_ctrl_act;
		else
			s_nxt.ext_en = s_nxt.ext_sw;
	end

	// single state register, every field cleared
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			s_r              <= '0;
			s_r.reg_on_slot  <= SLOT_RST;
			s_r.reg_slp_slot <= SLOT_RST;
			s_r.ext_on_slot  <= SLOT_RST;
			s_r.ext_slp_slot <= SLOT_RST;
			s_r.ext_src      <= SRC_RST;
			s_r.reg_on_vsel  <= VSEL_RST;
			s_r.reg_slp_vsel <= VSEL_RST;
		end
		else
			s_r <= s_nxt;
	end

	// helper: any write seen since reset
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			wrote_r <= 1'b0;
		else if (wr_go)
			wrote_r <= 1'b1;
	end

	// outputs straight from the state register
	assign WB_ACK_O  = s_r.ack;
	assign WB_DAT_O  = s_r.dat;
	assign REG_EN    = s_r.reg_en;
	assign REG_SLEEP = s_r.reg_sleep;
	assign REG_VSEL  = s_r.reg_vsel;
	assign EXT_EN    = s_r.ext_en;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);

	// checks
	a_reset_fields_zero: assert property (!wrote_r |-> s_r.reg_slp_slot == 3'h0 &&
		s_r.ext_on_slot == 3'h0 && s_r.ext_src == 2'h0 && !s_r.ext_hwcena && !EXT_EN)
		else $error("fields not zero before first write");
	a_reg_sleep_move: assert property (SEQ_SLOT_STB && SEQ_SLEEP &&
		s_r.reg_slp_slot == 3'h6 && SEQ_SLOT == 3'h3 |=> REG_SLEEP && $stable(s_r.reg_sw))
		else $error("sleep transition in slot 3 missing");
	a_reg_sleep_disable: assert property (SEQ_SLOT_STB && SEQ_SLEEP &&
		s_r.reg_slp_slot == 3'h1 && SEQ_SLOT == 3'h5 && s_r.reg_on_slot < 3'h6 |=> !s_r.reg_sw)
		else $error("regulator not disabled in slot 5");
	a_reg_hw_sleep: assert property (SEQ_SLOT_STB && SEQ_SLEEP &&
		s_r.reg_slp_slot == 3'h5 && SEQ_SLOT == 3'h1 && s_r.reg_on_slot >= 3'h6 |=> REG_SLEEP)
		else $error("hardware-enabled regulator did not enter sleep");
	a_sleep_vsel: assert property (REG_SLEEP |-> REG_VSEL == s_r.reg_slp_vsel)
		else $error("sleep voltage code not applied");
	a_ext_on_slot: assert property (SEQ_SLOT_STB && !SEQ_SLEEP &&
		s_r.ext_on_slot == SEQ_SLOT && SEQ_SLOT inside {[3'h1:3'h5]} |=> s_r.ext_sw)
		else $error("external enable not set in its slot");
	a_ext_sw_only: assert property (!s_r.ext_hwcena |-> EXT_EN == s_r.ext_sw)
		else $error("external enable not following software bit");
	a_hw_ctrl_low: assert property (s_nxt.ext_hwcena && s_nxt.ext_src == 2'h3 &&
		hw_ctrl_s != 2'h0 |=> !EXT_EN)
		else $error("hardware control did not force output low");
	a_ext_sleep_off: assert property (SEQ_SLOT_STB && SEQ_SLEEP &&
		s_r.ext_slp_slot == 3'h2 && SEQ_SLOT == 3'h4 |=> !s_r.ext_sw)
		else $error("external enable not cleared in slot 4");
	a_reg_on_slot: assert property (SEQ_SLOT_STB && !SEQ_SLEEP && s_r.reg_on_slot == 3'h2 &&
		SEQ_SLOT == 3'h2 ##1 s_r.reg_on_slot == 3'h2 |-> REG_EN)
		else $error("regulator not enabled in slot 2");
	a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");

	// scenarios
	c_reg_sleep: cover property (!REG_SLEEP ##1 REG_SLEEP);
	c_reg_on: cover property (!REG_EN ##1 REG_EN);
	c_hw_ctrl_override: cover property (s_r.ext_sw && s_r.ext_hwcena && !EXT_EN);
	c_bus_write: cover property (wr_go);

endmodule : rsc_slot_ctrl

// ### dv/rsc_seq_model.sv
// Purpose: sequencer timeslot engine model, one slot event per request
// Assumes: same clock as the block; requests arrive only when idle
// Notes:   event lines toggle between strobes so stale values never match
`timescale 1ns/1ps
module rsc_seq_model
	import rsc_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// request from the bench
	input  wire logic       req,
	input  wire logic       req_sleep,
	input  wire logic [2:0] req_slot,
	input  wire logic [3:0] gap,
	// event lines and completion
	output rsc_seq_t        ev,
	output logic            done
);
	logic [4:0] cnt_r;
	rsc_seq_t   hold_r;

	// wait gap cycles, strobe once, flag done a cycle later
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_r <= 5'h00;
			hold_r <= '0;
			ev <= '0;
			done <= 1'b0;
		end
		else
		begin
			done <= ev.stb;
			if (req)
			begin
				cnt_r <= {1'b0, gap} + 5'h01;
				hold_r <= '{stb: 1'b1, sleep: req_sleep, slot: req_slot};
			end
			else if (cnt_r == 5'h01)
			begin
				cnt_r <= 5'h00;
				ev <= hold_r;
			end
			else
			begin
				if (cnt_r != 5'h00)
					cnt_r <= cnt_r - 5'h01;
				ev.stb <= 1'b0;
				ev.sleep <= ~ev.sleep;
				ev.slot <= ~ev.slot;
			end
		end
	end
endmodule : rsc_seq_model

// ### dv/tb_top.sv
// Purpose: self-checking bench for the slot control block
// Assumes: one ack per request; outputs settle the cycle after an event
// Notes:   pins are checked on the fourth falling edge after they change
`timescale 1ns/1ps
module tb_top
	import rsc_pkg::*;
;
	// clock, reset and bus
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [17:0] adr = 18'h0_0000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	// sequencer, pins and outputs
	logic        req = 1'b0;
	logic        req_sleep = 1'b0;
	logic [2:0]  req_slot = 3'h0;
	logic [3:0]  gap = 4'h0;
	rsc_seq_t    ev;
	logic        done;
	logic [1:0]  hwen = 2'h0;
	logic [1:0]  hw_ctrl = 2'h0;
	logic        reg_en;
	logic        reg_sleep;
	logic [3:0]  reg_vsel;
	logic        ext_en;
	logic [31:0] rd;
	int          error_cnt = 0;
	int          check_count = 0;
	int          tslot [8] = '{5, 5, 4, 3, 2, 1, 3, 1};

	// clock
	always #2.5 clk = ~clk;

	rsc_slot_ctrl dut (
		.REF_CLK(clk), .ARST_N(arst_n),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.SEQ_SLOT_STB(ev.stb), .SEQ_SLEEP(ev.sleep), .SEQ_SLOT(ev.slot),
		.HWEN_PIN(hwen), .HW_CTRL_PIN(hw_ctrl), .REG_EN(reg_en),
		.REG_SLEEP(reg_sleep), .REG_VSEL(reg_vsel), .EXT_EN(ext_en)
	);

	rsc_seq_model seq_m (
		.clk(clk), .arst_n(arst_n), .req(req), .req_sleep(req_sleep),
		.req_slot(req_slot), .gap(gap), .ev(ev), .done(done)
	);

	task finish_test;
		if (error_cnt == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task bail(input int n);
		if (n >= 40)
		begin
			error_cnt++;
			finish_test();
		end
	endtask : bail

	// one classic cycle; ack and read data are taken at the same rising edge
	task wb(input logic w, input logic [15:0] idx, input logic [15:0] wd, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'h0};
		sel <= 4'h3;
		wdat <= {16'h0000, wd};
		@(posedge clk);
		while (ack !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		bail(n);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task wr(input logic [15:0] idx, input logic [15:0] wd);
		wb(1'b1, idx, wd, rd);
	endtask : wr

	task rdchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 16'h0000, rd);
		chk(nm, rd, exp);
	endtask : rdchk

	// one slot event, slower for higher slots
	task seq(input logic sl, input logic [2:0] s);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1;
		req_sleep <= sl;
		req_slot <= s;
		gap <= {1'b0, s};
		@(posedge clk);
		req <= 1'b0;
		@(negedge clk);
		while (done !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		bail(n);
	endtask : seq

	task pins(input logic [1:0] en, input logic [1:0] ct);
		@(posedge clk);
		hwen <= en;
		hw_ctrl <= ct;
		repeat (4) @(negedge clk);
	endtask : pins

	function automatic logic [15:0] xc(logic [2:0] on, logic [1:0] src, logic ena,
		logic [2:0] slp);
		return {on, src, 2'h0, ena, slp, 5'h00};
	endfunction : xc

	task t_reset;
		rdchk("rst_on", IDX_REG_ON, 32'h0000_0000);
		rdchk("rst_slp", IDX_REG_SLEEP, 32'h0000_0000);
		rdchk("rst_ext", IDX_EXT_CTRL, 32'h0000_0000);
		rdchk("unmapped", 16'h4000, 32'h0000_0000);
		wb(1'b0, IDX_STATUS, 16'h0000, rd);
		chk("rst_mv", 32'(rd[26:16]), 32'(VMIN_MV));
		chk("rst_out", 32'(rd[2:0]), 32'h0000_0000);
	endtask : t_reset

	task t_reg_on;
		wr(IDX_REG_ON, 16'h6000);
		wr(IDX_EXT_CTRL, xc(3'h2, 2'h0, 1'b0, 3'h0));
		for (int s = 1; s <= 5; s++)
		begin
			seq(1'b0, 3'(s));
			chk("reg_on", 32'(reg_en), 32'(s >= 3));
			chk("ext_on", 32'(ext_en), 32'(s >= 2));
		end
	endtask : t_reg_on

	task t_hwen;
		wr(IDX_REG_ON, 16'hC000);
		pins(2'h0, 2'h0);
		chk("hwen_off", 32'(reg_en), 32'h0000_0000);
		pins(2'h1, 2'h0);
		chk("hwen_on", 32'(reg_en), 32'h0000_0001);
		wr(IDX_REG_ON, 16'hE000);
		pins(2'h1, 2'h0);
		chk("hwen2_off", 32'(reg_en), 32'h0000_0000);
		pins(2'h2, 2'h0);
		chk("hwen2_on", 32'(reg_en), 32'h0000_0001);
		wr(IDX_REG_SLEEP, 16'hA000);
		seq(1'b1, 3'h1);
		chk("hw_slp_en", 32'(reg_en), 32'h0000_0001);
		chk("hw_slp", 32'(reg_sleep), 32'h0000_0001);
	endtask : t_hwen

	task t_sleep;
		logic       dis;
		logic [3:0] v;
		for (int c = 0; c < 8; c++)
		begin
			wr(IDX_REG_ON, 16'h2000);
			seq(1'b0, 3'h1);
			v = 4'hF - 4'(c);
			dis = (c >= 1) && (c <= 5);
			wr(IDX_REG_SLEEP, {3'(c), 9'h000, v});
			rdchk("slp_rb", IDX_REG_SLEEP, {16'h0000, 3'(c), 9'h000, v});
			for (int s = 5; s >= 1; s--)
			begin
				seq(1'b1, 3'(s));
				chk("slp_en", 32'(reg_en), 32'(!(dis && s <= tslot[c])));
				chk("slp_mode", 32'(reg_sleep), 32'(!dis && s <= tslot[c]));
			end
			if (!dis)
			begin
				chk("slp_vsel", 32'(reg_vsel), 32'(v));
				wb(1'b0, IDX_STATUS, 16'h0000, rd);
				chk("slp_mv", 32'(rd[26:16]), 32'(VMIN_MV) + 32'(VSTEP_MV) * 32'(v));
			end
		end
	endtask : t_sleep

	task t_ext;
		logic [1:0] src;
		wr(IDX_ENABLES, 16'h0001);
		wr(IDX_EXT_CTRL, xc(3'h0, 2'h3, 1'b0, 3'h0));
		pins(2'h0, 2'h3);
		chk("ext_sw", 32'(ext_en), 32'h0000_0001);
		for (int i = 0; i < 16; i++)
		begin
			src = 2'(i >> 2);
			wr(IDX_EXT_CTRL, xc(3'h0, src, 1'b1, 3'h0));
			pins(2'h0, 2'(i));
			chk("ext_hwc", 32'(ext_en), 32'(~|(src & 2'(i))));
		end
		for (int on = 6; on <= 7; on++)
		begin
			wr(IDX_EXT_CTRL, xc(3'(on), 2'h0, 1'b1, 3'h0));
			for (int h = 0; h < 4; h++)
			begin
				pins(2'(h), 2'h0);
				chk("ext_hwen", 32'(ext_en), 32'((on == 6) ? (h & 1) : (h >> 1)));
			end
		end
		pins(2'h0, 2'h0);
		for (int c = 0; c < 8; c++)
		begin
			wr(IDX_EXT_CTRL, xc(3'h0, 2'h0, 1'b0, 3'(c)));
			wr(IDX_ENABLES, 16'h0001);
			for (int s = 5; s >= 1; s--)
			begin
				seq(1'b1, 3'(s));
				chk("ext_slp", 32'(ext_en), 32'(!(c >= 1 && c <= 5 && s <= 6 - c)));
			end
		end
	endtask : t_ext

	// main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_reg_on();
		t_hwen();
		t_sleep();
		t_ext();
		finish_test();
	end
endmodule : tb_top
